// [rtl/iswl_walker.v]
// Lower levels of the second-stage walker: takes a fetched third-level entry,
// walks directory and leaf tables, checks rights, maintains accessed/dirty.
// Assumes memory answers reads with a data strobe and performs atomic OR updates.
// All inputs come from logic on ref_clk.
`include "iswl_consts.vh"

module iswl_walker #(
   parameter HOST_ADDR_WIDTH      = 48,
   parameter MAX_GUEST_ADDR_WIDTH = 48
) (
   input  wire        ref_clk,
   input  wire        sys_rst,
   input  wire        req_valid,
   output reg         req_ready_r,
   input  wire [63:0] req_addr,
   input  wire        req_is_write,
   input  wire        req_is_atomic,
   input  wire        execute_requested,
   input  wire        req_has_pasid,
   input  wire [63:0] level3_dir_pointer_entry,
   input  wire [63:0] level3_entry_addr,
   input  wire        upper_read_ok,
   input  wire        upper_write_ok,
   input  wire        upper_exec_ok,
   input  wire        stage2_execute_enable,
   input  wire        stage2_access_dirty_enable,
   input  wire        snoop_control_capability,
   input  wire        large_1g_supported,
   input  wire        large_2m_supported,
   output reg         mem_rd_req_r,
   output reg  [63:0] mem_rd_addr_r,
   input  wire        mem_rd_valid,
   input  wire [63:0] mem_rd_data,
   output reg         mem_upd_req_r,
   output reg  [63:0] mem_upd_addr_r,
   output reg  [63:0] mem_upd_mask_r,
   input  wire        mem_upd_done,
   output reg         res_valid_r,
   output reg         res_fault_r,
   output reg  [1:0]  res_fault_kind_r,
   output reg  [1:0]  res_page_kind_r,
   output reg  [63:0] res_phys_addr_r
);
   reg  [2:0]  state_r;
   reg  [2:0]  ret_state_r;
   reg  [2:0]  level_r;
   reg  [63:0] addr_r;
   reg  [63:0] entry_r;
   reg  [63:0] entry_addr_r;
   reg         is_write_r;
   reg         is_atomic_r;
   reg         exec_req_r;
   reg         has_pasid_r;
   reg         see_r;
   reg         ade_r;
   reg         rd_acc_r;
   reg         wr_acc_r;
   reg         ex_acc_r;

   wire        present;
   wire        entry_bad;
   wire        is_leaf;

   iswl_entry_check #(
      .HOST_ADDR_WIDTH (HOST_ADDR_WIDTH)
   ) u_check (
      .entry                    (entry_r),
      .level                    (level_r),
      .large_1g_supported       (large_1g_supported),
      .large_2m_supported       (large_2m_supported),
      .snoop_control_capability (snoop_control_capability),
      .present                  (present),
      .entry_bad                (entry_bad),
      .is_leaf                  (is_leaf)
   );

   // Rights accumulated over every entry including the one under check.
   wire        rd_all = rd_acc_r & entry_r[`ISWL_BIT_READ];
   wire        wr_all = wr_acc_r & entry_r[`ISWL_BIT_WRITE];
   wire        ex_all = ex_acc_r & entry_r[`ISWL_BIT_EXEC];

   // Execute rights only count for requests with an address-space id.
   wire        ex_ok  = !has_pasid_r || !see_r || ex_all;
   wire        read_ok  = rd_all && (!exec_req_r || ex_ok);
   wire        write_ok = wr_all;
   wire        atom_ok  = rd_all && wr_all;
   wire        permit   = is_atomic_r ? atom_ok : (is_write_r ? write_ok : read_ok);

   wire        acc_clear = !entry_r[`ISWL_BIT_ACCESSED];
   wire        dirty_clear = !entry_r[`ISWL_BIT_DIRTY];
   wire        need_dirty = (is_write_r || is_atomic_r) && permit && dirty_clear;

   // Update masks only ever OR ones into memory, so flags are never cleared.
   wire [63:0] acc_mask = {54'h0, 1'b0, acc_clear, 8'h00};
   wire [63:0] leaf_mask = {54'h0, need_dirty, acc_clear, 8'h00};

   wire [8:0]  next_index = (level_r == `ISWL_LVL_L3) ? addr_r[29:21] : addr_r[20:12];
   wire [63:0] next_tbl_addr = {12'h000, entry_r[51:12], next_index, 3'h0};

   reg  [63:0] phys_nxt;
   reg  [1:0]  page_kind_nxt;

   always @*
   begin
      phys_nxt      = {12'h000, entry_r[51:12], addr_r[11:0]};
      page_kind_nxt = `ISWL_PG_4K;
      if (level_r == `ISWL_LVL_DIR)
      begin
         phys_nxt      = {12'h000, entry_r[51:21], addr_r[20:0]};
         page_kind_nxt = `ISWL_PG_2M;
      end
      else if (level_r == `ISWL_LVL_L3)
      begin
         phys_nxt      = {12'h000, entry_r[51:30], addr_r[29:0]};
         page_kind_nxt = `ISWL_PG_1G;
      end
   end

   wire        out_of_range = (req_addr >> MAX_GUEST_ADDR_WIDTH) != 64'h0;

   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         state_r          <= `ISWL_ST_IDLE;
         ret_state_r      <= `ISWL_ST_IDLE;
         level_r          <= `ISWL_LVL_L3;
         addr_r           <= `ISWL_RST_ADDR;
         entry_r          <= `ISWL_RST_ENTRY;
         entry_addr_r     <= `ISWL_RST_ADDR;
         is_write_r       <= 1'b0;
         is_atomic_r      <= 1'b0;
         exec_req_r       <= 1'b0;
         has_pasid_r      <= 1'b0;
         see_r            <= 1'b0;
         ade_r            <= 1'b0;
         rd_acc_r         <= 1'b0;
         wr_acc_r         <= 1'b0;
         ex_acc_r         <= 1'b0;
         req_ready_r      <= 1'b1;
         mem_rd_req_r     <= 1'b0;
         mem_rd_addr_r    <= `ISWL_RST_ADDR;
         mem_upd_req_r    <= 1'b0;
         mem_upd_addr_r   <= `ISWL_RST_ADDR;
         mem_upd_mask_r   <= `ISWL_RST_ENTRY;
         res_valid_r      <= 1'b0;
         res_fault_r      <= 1'b0;
         res_fault_kind_r <= `ISWL_FLT_NONE;
         res_page_kind_r  <= `ISWL_PG_4K;
         res_phys_addr_r  <= `ISWL_RST_ADDR;
      end
      else
      begin
         res_valid_r <= 1'b0;
         case (state_r)
            `ISWL_ST_IDLE:
            begin
               if (req_valid)
               begin
                  req_ready_r  <= 1'b0;
                  addr_r       <= req_addr;
                  entry_r      <= level3_dir_pointer_entry;
                  entry_addr_r <= level3_entry_addr;
                  level_r      <= `ISWL_LVL_L3;
                  is_write_r   <= req_is_write;
                  is_atomic_r  <= req_is_atomic;
                  exec_req_r   <= execute_requested;
                  has_pasid_r  <= req_has_pasid;
                  see_r        <= stage2_execute_enable;
                  ade_r        <= stage2_access_dirty_enable;
                  rd_acc_r     <= upper_read_ok;
                  wr_acc_r     <= upper_write_ok;
                  ex_acc_r     <= upper_exec_ok;
                  if (out_of_range)
                  begin
                     // The walk is never started for an address past the guest width.
                     res_fault_kind_r <= `ISWL_FLT_RANGE;
                     state_r          <= `ISWL_ST_RESP;
                  end
                  else
                  begin
                     state_r <= `ISWL_ST_CHECK;
                  end
               end
            end
            `ISWL_ST_CHECK:
            begin
               if (entry_bad)
               begin
                  // No further reads or updates once an entry fails.
                  res_fault_kind_r <= `ISWL_FLT_ENTRY;
                  state_r          <= `ISWL_ST_RESP;
               end
               else if (is_leaf)
               begin
                  res_phys_addr_r  <= phys_nxt;
                  res_page_kind_r  <= page_kind_nxt;
                  res_fault_kind_r <= permit ? `ISWL_FLT_NONE : `ISWL_FLT_PERM;
                  // Accessed is set even when rights deny the access; dirty only on success.
                  if (ade_r && (acc_clear || need_dirty))
                  begin
                     mem_upd_req_r  <= 1'b1;
                     mem_upd_addr_r <= entry_addr_r;
                     mem_upd_mask_r <= leaf_mask;
                     ret_state_r    <= `ISWL_ST_RESP;
                     state_r        <= `ISWL_ST_UPDATE;
                  end
                  else
                  begin
                     state_r <= `ISWL_ST_RESP;
                  end
               end
               else
               begin
                  rd_acc_r      <= rd_all;
                  wr_acc_r      <= wr_all;
                  ex_acc_r      <= ex_all;
                  mem_rd_addr_r <= next_tbl_addr;
                  if (ade_r && acc_clear)
                  begin
                     mem_upd_req_r  <= 1'b1;
                     mem_upd_addr_r <= entry_addr_r;
                     mem_upd_mask_r <= acc_mask;
                     ret_state_r    <= `ISWL_ST_READ;
                     state_r        <= `ISWL_ST_UPDATE;
                  end
                  else
                  begin
                     mem_rd_req_r <= 1'b1;
                     state_r      <= `ISWL_ST_READ;
                  end
               end
            end
            `ISWL_ST_UPDATE:
            begin
               if (mem_upd_done)
               begin
                  mem_upd_req_r <= 1'b0;
                  mem_rd_req_r  <= (ret_state_r == `ISWL_ST_READ);
                  state_r       <= ret_state_r;
               end
            end
            `ISWL_ST_READ:
            begin
               // The read request may be raised on entry here after an update.
               mem_rd_req_r <= 1'b1;
               if (mem_rd_valid && mem_rd_req_r)
               begin
                  mem_rd_req_r <= 1'b0;
                  entry_r      <= mem_rd_data;
                  entry_addr_r <= mem_rd_addr_r;
                  level_r      <= level_r - 3'h1;
                  state_r      <= `ISWL_ST_CHECK;
               end
            end
            `ISWL_ST_RESP:
            begin
               res_valid_r <= 1'b1;
               res_fault_r <= (res_fault_kind_r != `ISWL_FLT_NONE);
               req_ready_r <= 1'b1;
               state_r     <= `ISWL_ST_IDLE;
            end
            default:
            begin
               state_r <= `ISWL_ST_IDLE;
            end
         endcase
      end
   end
endmodule

// [rtl/iswl_consts.vh]
// Constants for the lower second-stage page walker: entry field positions,
// walk levels, walker states, fault kinds and page kinds.
// Assumes 64-bit paging entries and 64-bit input and output addresses.
`ifndef ISWL_CONSTS_VH
`define ISWL_CONSTS_VH

// Paging entry field positions.
`define ISWL_BIT_READ       0
`define ISWL_BIT_WRITE      1
`define ISWL_BIT_EXEC       2
`define ISWL_BIT_PAGE_SIZE  7
`define ISWL_BIT_ACCESSED   8
`define ISWL_BIT_DIRTY      9
`define ISWL_BIT_SNOOP      11
`define ISWL_ADDR_TOP       51

// Walk levels.
`define ISWL_LVL_LEAF       3'h1
`define ISWL_LVL_DIR        3'h2
`define ISWL_LVL_L3         3'h3
`define ISWL_LVL_L4         3'h4
`define ISWL_LVL_L5         3'h5

// Walker states.
`define ISWL_ST_IDLE        3'h0
`define ISWL_ST_CHECK       3'h1
`define ISWL_ST_READ        3'h2
`define ISWL_ST_UPDATE      3'h3
`define ISWL_ST_RESP        3'h4

// Fault kinds.
`define ISWL_FLT_NONE       2'h0
`define ISWL_FLT_RANGE      2'h1
`define ISWL_FLT_ENTRY      2'h2
`define ISWL_FLT_PERM       2'h3

// Page kinds of a finished translation.
`define ISWL_PG_4K          2'h0
`define ISWL_PG_2M          2'h1
`define ISWL_PG_1G          2'h2

// Reset values.
`define ISWL_RST_ADDR       64'h0000000000000000
`define ISWL_RST_ENTRY      64'h0000000000000000

`endif

// [rtl/iswl_entry_check.v]
// Combinational check of one second-stage paging entry: presence,
// reserved-bit violations for its level, and whether it maps a page.
// Assumes the caller supplies the entry and its walk level in the same cycle.
`include "iswl_consts.vh"

module iswl_entry_check #(
   parameter HOST_ADDR_WIDTH = 48
) (
   input  wire [63:0] entry,
   input  wire [2:0]  level,
   input  wire        large_1g_supported,
   input  wire        large_2m_supported,
   input  wire        snoop_control_capability,
   output wire        present,
   output wire        entry_bad,
   output wire        is_leaf
);
   wire [63:0] hi_mask;
   wire        ps;
   wire        snoop_bit;
   wire        upper_lvl;
   wire        mid_lvl;
   wire        non_leaf;
   wire        rsvd;

   genvar i;
   generate
      for (i = 0; i < 64; i = i + 1)
      begin : g_mask
         assign hi_mask[i] = (i >= HOST_ADDR_WIDTH) && (i <= `ISWL_ADDR_TOP);
      end
   endgenerate

   assign ps        = entry[`ISWL_BIT_PAGE_SIZE];
   assign snoop_bit       = entry[`ISWL_BIT_SNOOP];
   assign present   = entry[`ISWL_BIT_READ] | entry[`ISWL_BIT_WRITE];
   assign upper_lvl = (level == `ISWL_LVL_L5) || (level == `ISWL_LVL_L4);
   assign mid_lvl   = (level == `ISWL_LVL_L3) || (level == `ISWL_LVL_DIR);
   assign non_leaf  = upper_lvl || (mid_lvl && !ps);

   assign rsvd = present &&
                 ((|(entry & hi_mask)) ||
                  (upper_lvl && ps) ||
                  ((level == `ISWL_LVL_L3) && !large_1g_supported && ps) ||
                  ((level == `ISWL_LVL_DIR) && !large_2m_supported && ps) ||
                  ((level == `ISWL_LVL_L3) && ps && (|entry[29:12])) ||
                  ((level == `ISWL_LVL_DIR) && ps && (|entry[20:12])) ||
                  (non_leaf && snoop_bit) ||
                  ((level == `ISWL_LVL_LEAF) && !snoop_control_capability && snoop_bit));

   // A non-present or reserved-violating entry is never followed.
   assign entry_bad = !present || rsvd;
   assign is_leaf   = (level == `ISWL_LVL_LEAF) || (mid_lvl && ps);
endmodule

// [verification/iswl_walker_chk.sv]
// Concurrent checks on the lower walker's ports: handshakes, result pulse, flag updates.
// Bound to every iswl_walker; sees only its ports.
module iswl_walker_chk #(
   parameter MAX_GUEST_ADDR_WIDTH = 48
) (
   input wire        ref_clk,
   input wire        sys_rst,
   input wire        req_valid,
   input wire        req_ready_r,
   input wire [63:0] req_addr,
   input wire        mem_rd_req_r,
   input wire [63:0] mem_rd_addr_r,
   input wire        mem_rd_valid,
   input wire        mem_upd_req_r,
   input wire [63:0] mem_upd_mask_r,
   input wire        mem_upd_done,
   input wire        res_valid_r,
   input wire        res_fault_r,
   input wire [1:0]  res_fault_kind_r
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);
   rd_hold_a: assert property (mem_rd_req_r && !mem_rd_valid |=> mem_rd_req_r && $stable(mem_rd_addr_r))
      else $error("table read dropped or moved before its data");
   rd_align_a: assert property (mem_rd_req_r |-> mem_rd_addr_r[2:0] == 3'h0)
      else $error("table read address not entry aligned");
   upd_mask_a: assert property (mem_upd_req_r |-> mem_upd_mask_r != 64'h0 && (mem_upd_mask_r & ~64'h300) == 64'h0)
      else $error("flag update touches bits other than accessed and dirty");
   upd_hold_a: assert property (mem_upd_req_r && !mem_upd_done |=> mem_upd_req_r)
      else $error("flag update dropped before completion");
   idle_quiet_a: assert property (req_ready_r |-> !mem_rd_req_r && !mem_upd_req_r)
      else $error("memory traffic while idle");
   one_access_a: assert property (!(mem_rd_req_r && mem_upd_req_r))
      else $error("read and update requested together");
   take_busy_a: assert property (req_valid && req_ready_r |=> !req_ready_r)
      else $error("walker stays ready after taking a request");
   res_pulse_a: assert property (res_valid_r |-> req_ready_r ##1 !res_valid_r)
      else $error("result not a single pulse with ready");
   range_a: assert property (req_valid && req_ready_r && |(req_addr >> MAX_GUEST_ADDR_WIDTH)
      |-> ##[1:3] res_valid_r && res_fault_r && res_fault_kind_r == 2'h1)
      else $error("out-of-range address not faulted");
   fault_kind_a: assert property (res_valid_r |-> res_fault_r == (res_fault_kind_r != 2'h0))
      else $error("fault flag disagrees with fault kind");
   cover property (mem_upd_req_r && mem_upd_done);
   cover property (res_valid_r && res_fault_kind_r == 2'h3);
   cover property (res_valid_r && !res_fault_r);
endmodule

bind iswl_walker iswl_walker_chk #(.MAX_GUEST_ADDR_WIDTH(MAX_GUEST_ADDR_WIDTH)) chk_i (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .req_valid(req_valid), .req_ready_r(req_ready_r),
   .req_addr(req_addr), .mem_rd_req_r(mem_rd_req_r), .mem_rd_addr_r(mem_rd_addr_r),
   .mem_rd_valid(mem_rd_valid), .mem_upd_req_r(mem_upd_req_r), .mem_upd_mask_r(mem_upd_mask_r),
   .mem_upd_done(mem_upd_done), .res_valid_r(res_valid_r), .res_fault_r(res_fault_r),
   .res_fault_kind_r(res_fault_kind_r));

// [verification/iswl_mem_model.sv]
// Behavioural system memory holding the paging tables: answers reads, applies atomic OR updates.
// Assumes requests are held until answered; slow stretches every answer.
module iswl_mem_model (
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic        slow,
   input  wire logic        rd_req,
   input  wire logic [63:0] rd_addr,
   output logic             rd_valid,
   output logic      [63:0] rd_data,
   input  wire logic        upd_req,
   input  wire logic [63:0] upd_addr,
   input  wire logic [63:0] upd_mask,
   output logic             upd_done
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [63:0] mem [logic [63:0]];
   int          wait_cnt = 0;
   int          rd_cnt = 0;
   int          upd_cnt = 0;
   initial {rd_valid, upd_done, rd_data} = '0;
   // Data toggles outside the strobe, so sampling at the wrong edge shows garbage, not a stale entry.
   always @(posedge ref_clk)
   begin
      rd_valid <= 1'b0;
      upd_done <= 1'b0;
      rd_data  <= ~rd_data;
      if (sys_rst)
         wait_cnt <= 0;
      else if ((rd_req || upd_req) && !rd_valid && !upd_done)
      begin
         if (wait_cnt < (slow ? 4 : 1))
            wait_cnt <= wait_cnt + 1;
         else
         begin
            wait_cnt <= 0;
            if (rd_req)
            begin
               rd_valid <= 1'b1;
               rd_data  <= mem.exists(rd_addr) ? mem[rd_addr] : 64'h0;
               rd_cnt++;
            end
            else
            begin
               upd_done <= 1'b1;
               mem[upd_addr] = (mem.exists(upd_addr) ? mem[upd_addr] : 64'h0) | upd_mask;
               upd_cnt++;
            end
         end
      end
   end
endmodule

// [verification/tb.sv]
// Self-checking bench for the lower walker: a table of walks against the memory model.
// Expects the walker, its checker and the memory model compiled first.
`include "iswl_consts.vh"
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [63:0] A0   = 64'h0000001234567ABC;
   localparam logic [63:0] L3A  = 64'h0000000000000100;
   localparam logic [63:0] DIRA = 64'h0000000000001000 + {A0[29:21], 3'h0};
   localparam logic [63:0] PTEA = 64'h0000000000002000 + {A0[20:12], 3'h0};
   logic        ref_clk = 1'b0, sys_rst = 1'b1, req_valid = 1'b0, slow = 1'b0, upper_write_ok = 1'b1;
   logic        req_is_write = 1'b0, req_is_atomic = 1'b0, execute_requested = 1'b0, req_has_pasid = 1'b0;
   logic        stage2_execute_enable = 1'b0, stage2_access_dirty_enable = 1'b0;
   logic        snoop_control_capability = 1'b0, large_2m_supported = 1'b0;
   logic [63:0] req_addr = 64'h0, cur_a = A0;
   logic        req_ready_r, mem_rd_req_r, mem_rd_valid, mem_upd_req_r, mem_upd_done, res_valid_r, res_fault_r;
   logic [63:0] mem_rd_addr_r, mem_rd_data, mem_upd_addr_r, mem_upd_mask_r, res_phys_addr_r;
   logic [1:0]  res_fault_kind_r, res_page_kind_r;
   int          err_count = 0, total_checks = 0, tests = 0, cycles = 0, u0;
   iswl_walker uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .req_valid(req_valid), .req_ready_r(req_ready_r),
      .req_addr(req_addr), .req_is_write(req_is_write), .req_is_atomic(req_is_atomic),
      .execute_requested(execute_requested), .req_has_pasid(req_has_pasid),
      .level3_dir_pointer_entry(64'h0000000000001007), .level3_entry_addr(L3A), .upper_read_ok(1'b1),
      .upper_write_ok(upper_write_ok), .upper_exec_ok(1'b1), .stage2_execute_enable(stage2_execute_enable),
      .stage2_access_dirty_enable(stage2_access_dirty_enable), .snoop_control_capability(snoop_control_capability),
      .large_1g_supported(1'b1), .large_2m_supported(large_2m_supported), .mem_rd_req_r(mem_rd_req_r),
      .mem_rd_addr_r(mem_rd_addr_r), .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data),
      .mem_upd_req_r(mem_upd_req_r), .mem_upd_addr_r(mem_upd_addr_r), .mem_upd_mask_r(mem_upd_mask_r),
      .mem_upd_done(mem_upd_done), .res_valid_r(res_valid_r), .res_fault_r(res_fault_r),
      .res_fault_kind_r(res_fault_kind_r), .res_page_kind_r(res_page_kind_r), .res_phys_addr_r(res_phys_addr_r));
   iswl_mem_model mem_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .slow(slow), .rd_req(mem_rd_req_r),
      .rd_addr(mem_rd_addr_r), .rd_valid(mem_rd_valid), .rd_data(mem_rd_data), .upd_req(mem_upd_req_r),
      .upd_addr(mem_upd_addr_r), .upd_mask(mem_upd_mask_r), .upd_done(mem_upd_done));
   always #20 ref_clk = ~ref_clk;
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // One walk from the idle state; the result fields are read in the cycle that res_valid_r is high.
   task automatic row(input logic [63:0] dir, input logic [63:0] pte, input logic [6:0] c,
                      input logic [1:0] kind, input int nrd);
      int r0;
      int n;
      tests++;
      mem_i.mem[DIRA] = dir;
      mem_i.mem[PTEA] = pte;
      {req_is_write, req_is_atomic, execute_requested, req_has_pasid, stage2_execute_enable,
       snoop_control_capability, large_2m_supported} = c;
      r0 = mem_i.rd_cnt;
      req_addr = cur_a;
      req_valid = 1'b1;
      @(posedge ref_clk);
      #1 req_valid = 1'b0;
      n = 0;
      while (res_valid_r !== 1'b1 && n < 300)
      begin
         @(posedge ref_clk);
         #1 n++;
      end
      check(res_fault_kind_r, kind);
      check(res_fault_r, kind != `ISWL_FLT_NONE);
      check(64'(mem_i.rd_cnt - r0), 64'(nrd));
      if (kind == `ISWL_FLT_NONE)
      begin
         check(res_page_kind_r, dir[7] ? `ISWL_PG_2M : `ISWL_PG_4K);
         check(res_phys_addr_r, dir[7] ? {12'h000, dir[51:21], A0[20:0]} : {12'h000, pte[51:12], A0[11:0]});
      end
      $display("test %0d done", tests);
   endtask
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         err_count++;
         report_and_stop();
      end
   end
   initial
   begin
      repeat (2) @(posedge ref_clk);
      #1 sys_rst = 1'b0;
      check(req_ready_r, 1'b1);
      check(res_valid_r, 1'b0);
      row(64'h2003, 64'h30003, 7'h03, `ISWL_FLT_NONE, 2);
      row(64'h400083, 64'h0, 7'h03, `ISWL_FLT_NONE, 1);
      row(64'h400083, 64'h0, 7'h02, `ISWL_FLT_ENTRY, 1);
      row(64'h401083, 64'h0, 7'h03, `ISWL_FLT_ENTRY, 1);
      row(64'h0004000000002003, 64'h30003, 7'h03, `ISWL_FLT_ENTRY, 1);
      row(64'h2000, 64'h30003, 7'h03, `ISWL_FLT_ENTRY, 1);
      row(64'h2803, 64'h30003, 7'h03, `ISWL_FLT_ENTRY, 1);
      row(64'h2003, 64'h30803, 7'h01, `ISWL_FLT_ENTRY, 2);
      row(64'h2003, 64'h30803, 7'h03, `ISWL_FLT_NONE, 2);
      row(64'h2003, 64'h30001, 7'h43, `ISWL_FLT_PERM, 2);
      row(64'h2003, 64'h30001, 7'h23, `ISWL_FLT_PERM, 2);
      row(64'h2003, 64'h30002, 7'h03, `ISWL_FLT_PERM, 2);
      row(64'h2007, 64'h30003, 7'h1F, `ISWL_FLT_PERM, 2);
      row(64'h2007, 64'h30003, 7'h17, `ISWL_FLT_NONE, 2);
      row(64'h2007, 64'h30003, 7'h1B, `ISWL_FLT_NONE, 2);
      row(64'h2007, 64'h30007, 7'h1F, `ISWL_FLT_NONE, 2);
      upper_write_ok = 1'b0;
      row(64'h2003, 64'h30003, 7'h43, `ISWL_FLT_PERM, 2);
      upper_write_ok = 1'b1;
      cur_a = A0 | 64'h0001000000000000;
      row(64'h2003, 64'h30003, 7'h03, `ISWL_FLT_RANGE, 0);
      cur_a = A0;
      stage2_access_dirty_enable = 1'b1;
      slow = 1'b1;
      mem_i.mem[L3A] = 64'h1007;
      row(64'h2003, 64'h30003, 7'h43, `ISWL_FLT_NONE, 2);
      check(mem_i.mem[L3A], 64'h1107);
      check(mem_i.mem[DIRA], 64'h2103);
      check(mem_i.mem[PTEA], 64'h30303);
      u0 = mem_i.upd_cnt;
      // The third-level entry arrives on a port with accessed clear, so only it is updated again.
      row(64'h2103, 64'h30303, 7'h43, `ISWL_FLT_NONE, 2);
      check(64'(mem_i.upd_cnt - u0), 64'h1);
      row(64'h2103, 64'h30001, 7'h43, `ISWL_FLT_PERM, 2);
      check(mem_i.mem[PTEA][9], 1'b0);
      report_and_stop();
   end
endmodule
